/* rtl/mpg_gpio.v */
// Multi-port GPIO block: per-port slice and top with register port
`include "mpg_gpio_map.vh"
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// One port slice
module mpg_port #(
   parameter       WIDTH      = 8,
   parameter [7:0] PU_MASK    = 8'hFF,
   parameter       OPEN_DRAIN = 0
) (
   input  wire             clock,
   input  wire             rst_n,
   input  wire [7:0]       wr_data,
   input  wire             wr_lat,
   input  wire             wr_dir,
   input  wire             wr_pup,
   input  wire [WIDTH-1:0] pin_in,
   input  wire [WIDTH-1:0] alt_oe,
   input  wire [WIDTH-1:0] osc_taken,
   output wire [WIDTH-1:0] pin_out,
   output wire [WIDTH-1:0] pin_oe,
   output wire [WIDTH-1:0] pup_on,
   output reg  [7:0]       rd_lat,
   output reg  [7:0]       rd_dir,
   output reg  [7:0]       rd_pup
);
   reg  [WIDTH-1:0] lat_ff;
   reg  [WIDTH-1:0] dir_ff;
   reg  [WIDTH-1:0] pup_ff;
   reg  [WIDTH-1:0] sync1_ff;
   reg  [WIDTH-1:0] sync2_ff;
   wire [WIDTH-1:0] pup_mask;
   integer          i;

   assign pup_mask = PU_MASK[WIDTH-1:0];

   // =======================================================================
   // Registers
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lat_ff <= {WIDTH{`MPG_ZERO_FILL}};
         dir_ff <= {WIDTH{`MPG_DIR_FILL}};
         pup_ff <= {WIDTH{`MPG_ZERO_FILL}};
      end else begin
         if (wr_lat) begin
            lat_ff <= wr_data[WIDTH-1:0];
         end
         if (wr_dir) begin
            dir_ff <= wr_data[WIDTH-1:0];
         end
         if (wr_pup) begin
            pup_ff <= wr_data[WIDTH-1:0] & pup_mask;
         end
      end
   end

   // =======================================================================
   // Pin synchroniser, pins are asynchronous to the clock
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1_ff <= {WIDTH{`MPG_ZERO_FILL}};
         sync2_ff <= {WIDTH{`MPG_ZERO_FILL}};
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
      end
   end

   // =======================================================================
   // Pin drive
   generate
      if (OPEN_DRAIN != 0) begin : g_od
         // Never drives high; a one releases the pin
         assign pin_out = {WIDTH{`MPG_ZERO_FILL}};
         assign pin_oe  = ~dir_ff & ~lat_ff & ~osc_taken;
      end else begin : g_pp
         assign pin_out = lat_ff;
         assign pin_oe  = ~dir_ff & ~osc_taken;
      end
   endgenerate

   // Alternate outputs and output mode both keep the pull-up off
   assign pup_on = pup_ff & dir_ff & ~alt_oe & ~osc_taken & pup_mask;

   // =======================================================================
   // Read views, upper bits padded
   always @* begin
      rd_lat = `MPG_RD_NONE;
      rd_dir = {8{`MPG_DIR_FILL}};
      rd_pup = `MPG_RD_NONE;
      for (i = 0; i < WIDTH; i = i + 1) begin
         if (osc_taken[i]) begin
            rd_lat[i] = `MPG_ZERO_FILL;
         end else if (dir_ff[i]) begin
            rd_lat[i] = sync2_ff[i];
         end else begin
            rd_lat[i] = lat_ff[i];
         end
         rd_dir[i] = dir_ff[i];
         rd_pup[i] = pup_ff[i];
      end
   end
endmodule

// ==========================================================================
// Top: register port and five ports
module mpg_gpio (
   input  wire       clock,
   input  wire       rst_n,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire [1:0] p0_in,
   input  wire [1:0] p0_alt_oe,
   output wire [1:0] p0_out,
   output wire [1:0] p0_oe,
   output wire [1:0] p0_pullup,
   input  wire [7:0] p1_in,
   input  wire [7:0] p1_alt_oe,
   output wire [7:0] p1_out,
   output wire [7:0] p1_oe,
   output wire [7:0] p1_pullup,
   input  wire [3:0] p3_in,
   input  wire [3:0] p3_alt_oe,
   output wire [3:0] p3_out,
   output wire [3:0] p3_oe,
   output wire [3:0] p3_pullup,
   input  wire [1:0] p6_in,
   output wire [1:0] p6_out,
   output wire [1:0] p6_oe,
   input  wire [2:0] p12_in,
   input  wire [2:0] p12_alt_oe,
   output wire [2:0] p12_out,
   output wire [2:0] p12_oe,
   output wire [2:0] p12_pullup,
   output wire [1:0] clk_mode,
   output wire       osc_pins_taken
);
   reg  [1:0] clk_mode_ff;
   reg  [7:0] nxt_rdata;
   wire [7:0] lat0_v, dir0_v, pup0_v;
   wire [7:0] lat1_v, dir1_v, pup1_v;
   wire [7:0] lat3_v, dir3_v, pup3_v;
   wire [7:0] lat6_v, dir6_v, pup6_v;
   wire [7:0] lat12_v, dir12_v, pup12_v;
   wire [2:0] osc_mask;
   wire [1:0] p6_pup_unused;
   wire       wr_lat0;
   wire       wr_lat1;
   wire       wr_lat3;
   wire       wr_lat6;
   wire       wr_lat12;
   wire       wr_dir0;
   wire       wr_dir1;
   wire       wr_dir3;
   wire       wr_dir6;
   wire       wr_dir12;
   wire       wr_pup0;
   wire       wr_pup1;
   wire       wr_pup3;
   wire       wr_pup6;
   wire       wr_pup12;

   // =======================================================================
   // Clock mode select; oscillator modes take the two upper pins of port 12
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         clk_mode_ff <= `MPG_CLKMODE_RST;
      end else if (reg_wr && reg_addr == `MPG_OFS_CLKMODE) begin
         clk_mode_ff <= reg_wdata[1:0];
      end
   end

   assign clk_mode       = clk_mode_ff;
   assign osc_pins_taken = (clk_mode_ff != `MPG_CLKMODE_PORT);
   assign osc_mask       = osc_pins_taken ? `MPG_OSC_PINS : 3'h0;

   // =======================================================================
   // Write decode; one strobe per register
   assign wr_lat0  = reg_wr && reg_addr == `MPG_OFS_LAT0;
   assign wr_lat1  = reg_wr && reg_addr == `MPG_OFS_LAT1;
   assign wr_lat3  = reg_wr && reg_addr == `MPG_OFS_LAT3;
   assign wr_lat6  = reg_wr && reg_addr == `MPG_OFS_LAT6;
   assign wr_lat12 = reg_wr && reg_addr == `MPG_OFS_LAT12;
   assign wr_dir0  = reg_wr && reg_addr == `MPG_OFS_DIR0;
   assign wr_dir1  = reg_wr && reg_addr == `MPG_OFS_DIR1;
   assign wr_dir3  = reg_wr && reg_addr == `MPG_OFS_DIR3;
   assign wr_dir6  = reg_wr && reg_addr == `MPG_OFS_DIR6;
   assign wr_dir12 = reg_wr && reg_addr == `MPG_OFS_DIR12;
   assign wr_pup0  = reg_wr && reg_addr == `MPG_OFS_PUP0;
   assign wr_pup1  = reg_wr && reg_addr == `MPG_OFS_PUP1;
   assign wr_pup3  = reg_wr && reg_addr == `MPG_OFS_PUP3;
   assign wr_pup12 = reg_wr && reg_addr == `MPG_OFS_PUP12;
   // Lands in a register the empty mask holds at zero, so it stays unmapped
   assign wr_pup6  = reg_wr && reg_addr == `MPG_OFS_PUP6;

   // =======================================================================
   // Ports: seventeen push-pull, two open drain, fifteen pull-ups
   mpg_port #(.WIDTH(2), .PU_MASK(`MPG_PU_MASK0), .OPEN_DRAIN(0)) u_p0 (
      .clock     (clock),
      .rst_n     (rst_n),
      .wr_data   (reg_wdata),
      .wr_lat    (wr_lat0),
      .wr_dir    (wr_dir0),
      .wr_pup    (wr_pup0),
      .pin_in    (p0_in),
      .alt_oe    (p0_alt_oe),
      .osc_taken (2'h0),
      .pin_out   (p0_out),
      .pin_oe    (p0_oe),
      .pup_on    (p0_pullup),
      .rd_lat    (lat0_v),
      .rd_dir    (dir0_v),
      .rd_pup    (pup0_v)
   );

   mpg_port #(.WIDTH(8), .PU_MASK(`MPG_PU_MASK1), .OPEN_DRAIN(0)) u_p1 (
      .clock     (clock),
      .rst_n     (rst_n),
      .wr_data   (reg_wdata),
      .wr_lat    (wr_lat1),
      .wr_dir    (wr_dir1),
      .wr_pup    (wr_pup1),
      .pin_in    (p1_in),
      .alt_oe    (p1_alt_oe),
      .osc_taken (8'h00),
      .pin_out   (p1_out),
      .pin_oe    (p1_oe),
      .pup_on    (p1_pullup),
      .rd_lat    (lat1_v),
      .rd_dir    (dir1_v),
      .rd_pup    (pup1_v)
   );

   mpg_port #(.WIDTH(4), .PU_MASK(`MPG_PU_MASK3), .OPEN_DRAIN(0)) u_p3 (
      .clock     (clock),
      .rst_n     (rst_n),
      .wr_data   (reg_wdata),
      .wr_lat    (wr_lat3),
      .wr_dir    (wr_dir3),
      .wr_pup    (wr_pup3),
      .pin_in    (p3_in),
      .alt_oe    (p3_alt_oe),
      .osc_taken (4'h0),
      .pin_out   (p3_out),
      .pin_oe    (p3_oe),
      .pup_on    (p3_pullup),
      .rd_lat    (lat3_v),
      .rd_dir    (dir3_v),
      .rd_pup    (pup3_v)
   );

   // The pull-up register of this port stays zero under its empty mask
   mpg_port #(.WIDTH(2), .PU_MASK(`MPG_PU_MASK6), .OPEN_DRAIN(1)) u_p6 (
      .clock     (clock),
      .rst_n     (rst_n),
      .wr_data   (reg_wdata),
      .wr_lat    (wr_lat6),
      .wr_dir    (wr_dir6),
      .wr_pup    (wr_pup6),
      .pin_in    (p6_in),
      .alt_oe    (2'h0),
      .osc_taken (2'h0),
      .pin_out   (p6_out),
      .pin_oe    (p6_oe),
      .pup_on    (p6_pup_unused),
      .rd_lat    (lat6_v),
      .rd_dir    (dir6_v),
      .rd_pup    (pup6_v)
   );

   mpg_port #(.WIDTH(3), .PU_MASK(`MPG_PU_MASK12), .OPEN_DRAIN(0)) u_p12 (
      .clock     (clock),
      .rst_n     (rst_n),
      .wr_data   (reg_wdata),
      .wr_lat    (wr_lat12),
      .wr_dir    (wr_dir12),
      .wr_pup    (wr_pup12),
      .pin_in    (p12_in),
      .alt_oe    (p12_alt_oe),
      .osc_taken (osc_mask),
      .pin_out   (p12_out),
      .pin_oe    (p12_oe),
      .pup_on    (p12_pullup),
      .rd_lat    (lat12_v),
      .rd_dir    (dir12_v),
      .rd_pup    (pup12_v)
   );

   // =======================================================================
   // Read decode; unmapped offsets read zero, reads have no side effect
   always @* begin
      case (reg_addr)
         `MPG_OFS_LAT0:    nxt_rdata = lat0_v;
         `MPG_OFS_LAT1:    nxt_rdata = lat1_v;
         `MPG_OFS_LAT3:    nxt_rdata = lat3_v;
         `MPG_OFS_LAT6:    nxt_rdata = lat6_v;
         `MPG_OFS_LAT12:   nxt_rdata = lat12_v;
         `MPG_OFS_DIR0:    nxt_rdata = dir0_v;
         `MPG_OFS_DIR1:    nxt_rdata = dir1_v;
         `MPG_OFS_DIR3:    nxt_rdata = dir3_v;
         `MPG_OFS_DIR6:    nxt_rdata = dir6_v;
         `MPG_OFS_DIR12:   nxt_rdata = dir12_v;
         `MPG_OFS_PUP0:    nxt_rdata = pup0_v;
         `MPG_OFS_PUP1:    nxt_rdata = pup1_v;
         `MPG_OFS_PUP3:    nxt_rdata = pup3_v;
         `MPG_OFS_PUP12:   nxt_rdata = pup12_v;
         `MPG_OFS_CLKMODE: nxt_rdata = {6'h00, clk_mode_ff};
         default:          nxt_rdata = `MPG_RD_NONE;
      endcase
   end

   // Data valid only in the cycle after the read strobe
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `MPG_RD_NONE;
      end else if (reg_rd) begin
         reg_rdata <= nxt_rdata;
      end else begin
         reg_rdata <= `MPG_RD_NONE;
      end
   end
endmodule

`default_nettype wire

/* rtl/mpg_gpio_map.vh */
// Register offsets, reset values and field codes of the multi-port GPIO block
`ifndef MPG_GPIO_MAP_VH
`define MPG_GPIO_MAP_VH

// ==========================================================================
// Output latch offsets
`define MPG_OFS_LAT0      8'h00
`define MPG_OFS_LAT1      8'h01
`define MPG_OFS_LAT3      8'h03
`define MPG_OFS_LAT6      8'h06
`define MPG_OFS_LAT12     8'h0C

// ==========================================================================
// Direction offsets
`define MPG_OFS_DIR0      8'h20
`define MPG_OFS_DIR1      8'h21
`define MPG_OFS_DIR3      8'h23
`define MPG_OFS_DIR6      8'h26
`define MPG_OFS_DIR12     8'h2C

// ==========================================================================
// Pull-up enable offsets
`define MPG_OFS_PUP0      8'h30
`define MPG_OFS_PUP1      8'h31
`define MPG_OFS_PUP3      8'h33
`define MPG_OFS_PUP12     8'h3C
`define MPG_OFS_PUP6      8'h36

// ==========================================================================
// Clock mode select offset
`define MPG_OFS_CLKMODE   8'h40

// ==========================================================================
// Reset values and fill values
`define MPG_LAT_RST       8'h00
`define MPG_DIR_RST       8'hFF
`define MPG_PUP_RST       8'h00
`define MPG_CLKMODE_RST   2'h0
`define MPG_RD_NONE       8'h00
`define MPG_DIR_FILL      1'b1
`define MPG_ZERO_FILL     1'b0

// ==========================================================================
// Clock mode field codes
`define MPG_CLKMODE_PORT  2'h0
`define MPG_CLKMODE_XTAL  2'h1
`define MPG_CLKMODE_EXT   2'h2

// ==========================================================================
// Pull-up capable pins per port
`define MPG_PU_MASK0      8'h03
`define MPG_PU_MASK1      8'hFF
`define MPG_PU_MASK3      8'h0F
`define MPG_PU_MASK6      8'h00
`define MPG_PU_MASK12     8'h01

// ==========================================================================
// Oscillator pin positions in the fifth port
`define MPG_OSC_PINS      3'h6

`endif

/* sim/mpg_gpio_properties.sv */
// Assertion checker for the multi-port GPIO top
`timescale 1ns/100ps
`default_nettype none
module mpg_gpio_properties (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] p0_oe,
   input wire logic [7:0] p1_alt_oe,
   input wire logic [7:0] p1_out,
   input wire logic [7:0] p1_oe,
   input wire logic [7:0] p1_pullup,
   input wire logic [3:0] p3_oe,
   input wire logic [1:0] p6_out,
   input wire logic [1:0] p6_oe,
   input wire logic [2:0] p12_oe,
   input wire logic [2:0] p12_pullup,
   input wire logic [1:0] clk_mode,
   input wire logic       osc_pins_taken
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_dir1; reg_wr && reg_addr == 8'h21 |=> p1_oe == ~$past(reg_wdata); endproperty
   a_dir1: assert property (p_dir1) else $error("p1 direction");
   property p_lat1; reg_wr && reg_addr == 8'h01 |=> p1_out == $past(reg_wdata); endproperty
   a_lat1: assert property (p_lat1) else $error("p1 latch");
   property p_pu1; (p1_pullup & (p1_oe | p1_alt_oe)) == 8'h00; endproperty
   a_pu1: assert property (p_pu1) else $error("p1 pull-up");
   property p_od; p6_out == 2'h0; endproperty
   a_od: assert property (p_od) else $error("p6 drives high");
   property p_pu12; p12_pullup[2:1] == 2'h0; endproperty
   a_pu12: assert property (p_pu12) else $error("p12 pull-up");
   property p_rst;
      $rose(rst_n) |-> {p0_oe, p1_oe, p3_oe, p6_oe, p12_oe} == 19'h0 && clk_mode == 2'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_osc; osc_pins_taken |-> p12_oe[2:1] == 2'h0 && clk_mode != 2'h0; endproperty
   a_osc: assert property (p_osc) else $error("osc pins");
   property p_rdl; reg_rd && reg_addr == 8'h01 && p1_oe == 8'hFF |=> reg_rdata == p1_out;
   endproperty
   a_rdl: assert property (p_rdl) else $error("latch read");
endmodule
bind mpg_gpio mpg_gpio_properties u_props (.*);
`default_nettype wire

/* sim/mpg_pin_model.sv */
// Pin-side model: board drive, pull-ups and floating lines
`timescale 1ns/100ps
`default_nettype none
module mpg_pin_model #(
   parameter W  = 8,
   parameter BP = 0
) (
   input  wire logic         clock,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] pu,
   input  wire logic [W-1:0] drv,
   input  wire logic [W-1:0] den,
   output var  logic [W-1:0] lvl
);
   logic [W-1:0] last_ff = '0;
   // Floating pins toggle, so a stale level never passes as a real one
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (oe[i])
            lvl[i] = out[i];
         else if (den[i])
            lvl[i] = drv[i];
         else if (pu[i] || BP != 0)
            lvl[i] = 1'b1;
         else
            lvl[i] = ~last_ff[i];
      end
   end
   always @(posedge clock) last_ff <= lvl;
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the multi-port GPIO block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   // ==========
   // Signals
   logic       clock, rst_n, reg_wr, reg_rd, osc;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] p0_in, p0_out, p0_oe, p0_pu, a0, d0, e0, clk_mode;
   logic [1:0] p6_in, p6_out, p6_oe, d6, e6, pu6;
   logic [7:0] p1_in, p1_out, p1_oe, p1_pu, a1, d1, e1;
   logic [3:0] p3_in, p3_out, p3_oe, p3_pu, a3, d3, e3;
   logic [2:0] p12_in, p12_out, p12_oe, p12_pu, a12, d12, e12;
   int         mismatches, checked;
   mpg_gpio uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_mode(clk_mode),
      .osc_pins_taken(osc), .p0_in(p0_in), .p0_alt_oe(a0), .p0_out(p0_out), .p0_oe(p0_oe),
      .p0_pullup(p0_pu), .p1_in(p1_in), .p1_alt_oe(a1), .p1_out(p1_out), .p1_oe(p1_oe),
      .p1_pullup(p1_pu), .p3_in(p3_in), .p3_alt_oe(a3), .p3_out(p3_out), .p3_oe(p3_oe),
      .p3_pullup(p3_pu), .p6_in(p6_in), .p6_out(p6_out), .p6_oe(p6_oe), .p12_in(p12_in),
      .p12_alt_oe(a12), .p12_out(p12_out), .p12_oe(p12_oe), .p12_pullup(p12_pu));
   mpg_pin_model #(.W(2)) m0 (.clock(clock), .out(p0_out), .oe(p0_oe), .pu(p0_pu),
      .drv(d0), .den(e0), .lvl(p0_in));
   mpg_pin_model #(.W(8)) m1 (.clock(clock), .out(p1_out), .oe(p1_oe), .pu(p1_pu),
      .drv(d1), .den(e1), .lvl(p1_in));
   mpg_pin_model #(.W(4)) m3 (.clock(clock), .out(p3_out), .oe(p3_oe), .pu(p3_pu),
      .drv(d3), .den(e3), .lvl(p3_in));
   // Board pull-up on the open-drain pair
   mpg_pin_model #(.W(2), .BP(1)) m6 (.clock(clock), .out(p6_out), .oe(p6_oe), .pu(pu6),
      .drv(d6), .den(e6), .lvl(p6_in));
   mpg_pin_model #(.W(3)) m12 (.clock(clock), .out(p12_out), .oe(p12_oe), .pu(p12_pu),
      .drv(d12), .den(e12), .lvl(p12_in));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ==========
   // Bus and check tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      chk(reg_rdata, e);
   endtask
   task automatic do_reset;
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
   endtask
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ==========
   // Scenarios
   task automatic t_reset;
      logic [7:0] dirs [5];
      dirs = '{8'h20, 8'h21, 8'h23, 8'h26, 8'h2C};
      @(negedge clock);
      chk({p0_oe, p6_oe, p3_oe}, 8'h00);
      chk(p1_oe | p1_out, 8'h00);
      chk({5'h0, p12_oe}, 8'h00);
      chk({6'h00, clk_mode}, 8'h00);
      foreach (dirs[i]) rc(dirs[i], 8'hFF);
      rc(8'h31, 8'h00);
      rc(8'h40, 8'h00);
   endtask
   task automatic t_out;
      @(posedge clock);
      d1 <= 8'h03;
      e1 <= 8'h0F;
      wr(8'h01, 8'hA5);
      wr(8'h21, 8'h0F);
      @(negedge clock);
      chk(p1_oe, 8'hF0);
      rc(8'h01, 8'hA3);
      wr(8'h21, 8'h00);
      rc(8'h01, 8'hA5);
      wr(8'h00, 8'h02);
      wr(8'h20, 8'h00);
      wr(8'h03, 8'h05);
      wr(8'h23, 8'hFC);
      wr(8'h0C, 8'h06);
      wr(8'h2C, 8'hF8);
      @(negedge clock);
      chk({4'h0, p0_oe, p0_out}, 8'h0E);
      chk({p3_oe, p3_out}, 8'h35);
      chk({2'h0, p12_oe, p12_out}, 8'h3E);
   endtask
   task automatic t_pull;
      @(posedge clock);
      e1 <= 8'h00;
      wr(8'h21, 8'hFF);
      wr(8'h31, 8'hFF);
      rc(8'h31, 8'hFF);
      rc(8'h01, 8'hFF);
      @(posedge clock);
      a1 <= 8'h01;
      wr(8'h21, 8'hFD);
      @(negedge clock);
      chk(p1_pu, 8'hFC);
      wr(8'h20, 8'hFF);
      wr(8'h30, 8'hFF);
      rc(8'h30, 8'h03);
      chk({6'h0, p0_pu}, 8'h03);
      wr(8'h23, 8'hFF);
      wr(8'h33, 8'hFF);
      rc(8'h33, 8'h0F);
      chk({4'h0, p3_pu}, 8'h0F);
      wr(8'h2C, 8'hFF);
      wr(8'h3C, 8'hFF);
      rc(8'h3C, 8'h01);
      chk({5'h0, p12_pu}, 8'h01);
      @(posedge clock);
      a0  <= 2'h2;
      a3  <= 4'h8;
      a12 <= 3'h1;
      @(negedge clock);
      chk({2'h0, p0_pu, p3_pu}, 8'h17);
      chk({5'h0, p12_pu}, 8'h00);
   endtask
   task automatic t_od;
      wr(8'h06, 8'h02);
      wr(8'h26, 8'h00);
      @(negedge clock);
      chk({4'h0, p6_oe, p6_out}, 8'h04);
      rc(8'h06, 8'h02);
      rc(8'h36, 8'h00);
      wr(8'h26, 8'hFF);
      repeat (2) @(posedge clock);
      rc(8'h06, 8'h03);
   endtask
   task automatic t_osc;
      wr(8'h0C, 8'h07);
      wr(8'h2C, 8'h00);
      for (int m = 3; m >= 0; m--) begin
         wr(8'h40, 8'(m));
         @(negedge clock);
         chk({2'h0, clk_mode, p12_oe, osc}, {2'h0, 2'(m), (m == 0 ? 4'hE : 4'h3)});
         rc(8'h0C, m == 0 ? 8'h07 : 8'h01);
      end
   endtask
   initial begin
      {rst_n, reg_wr, reg_rd} = 3'h0;
      {reg_addr, reg_wdata} = 16'h0000;
      {a0, a1, a3, a12} = 17'h0;
      pu6 = 2'h0;
      {d0, d1, d3, d6, d12} = 19'h0;
      {e0, e1, e3, e6, e12} = {2'h3, 8'hFF, 4'hF, 2'h0, 3'h7};
      do_reset;
      t_reset;
      $display("reset test done");
      t_out;
      $display("output test done");
      t_pull;
      $display("pull-up test done");
      t_od;
      $display("open-drain test done");
      t_osc;
      $display("oscillator test done");
      do_reset;
      t_reset;
      $display("second reset test done");
      report_and_stop;
   end
   // Hang guard, far beyond the roughly 135 cycles the tests need
   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      report_and_stop;
   end
endmodule
`default_nettype wire
